// file: gpsm_board_model.sv
`timescale 1ns/1ns
`default_nettype none
module gpsm_board_model (
  // Pin from the block.
  input  wire logic general_pin_one_o,
  input  wire logic general_pin_one_oe,
  // Level seen by the board.
  output logic      board_level
);
  // The board pulls the pin down, so an undriven pin reads low.
  assign board_level = general_pin_one_oe ? general_pin_one_o : 1'b0;
endmodule
`default_nettype wire

// file: gpsm_pin_mux.sv
// How it works
// R1 - Source bits 4:2 pick receive port 0-3, device status or transmit port.
// R2 - Receive source: selector 000 and 011 drive remote pins 0 and 3.
// R3 - Receive source: selector 100 gives lock, 101 gives pass.
// R4 - Receive source: selector 110 gives frame-valid, 111 gives line-valid.
// R5 - Device status source: selector 000 drives the register level bit.
// R6 - Device status 001: OR of lock over enabled receive ports.
// R7 - Device status 010: AND of lock over enabled receive ports.
// R8 - Device status 011: AND of pass over enabled receive ports.
// R9 - Device status selectors 101 to 111 are reserved.
// R10 - Transmit source: 000 ANDs, 001 ORs pass of selected ports.
// R11 - Transmit source: 010 frame-valid, 011 line-valid of sent video.
// R12 - Transmit source: 100 shows multi-port data synchronized.
// R13 - Transmit source: 101 shows transmit interrupt; 110 and 111 reserved.
// R14 - Bit 1 holds the level for the register-driven selection.
// R15 - Bit 0 enables the pin driver; all fields reset to zero.
// R16 - Receive selectors 001 and 010 drive remote pins 1 and 2.
// R17 - Device status selector 100 drives the frame sync pulse.
//
// Implementation choice: register access over APB.
`timescale 1ns/1ns
`default_nettype none
`include "gpsm_regs.svh"

module gpsm_pin_mux
  import gpsm_pkg::*;
(
  // Clock and reset.
  input  wire logic        pclk,
  input  wire logic        presetn,
  // APB slave.
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  // Receive port status, from the port clock domains.
  input  wire logic [15:0] rx_remote_pins,
  input  wire logic [3:0]  rx_lock,
  input  wire logic [3:0]  rx_pass,
  input  wire logic [3:0]  rx_frame_valid,
  input  wire logic [3:0]  rx_line_valid,
  // Transmit port and device status.
  input  wire logic        tx_frame_valid,
  input  wire logic        tx_line_valid,
  input  wire logic        tx_synced,
  input  wire logic        tx_interrupt,
  input  wire logic        frame_sync_pulse,
  // Pin toward the board.
  output logic             general_pin_one_o,
  output logic             general_pin_one_oe
);

  localparam int SYNC_W = 37;

  // Input synchronisers: three stages, value accepted when the last two stages agree.
  logic [SYNC_W-1:0] raw_in;
  logic [SYNC_W-1:0] s1_q;
  logic [SYNC_W-1:0] s2_q;
  logic [SYNC_W-1:0] s3_q;
  logic [SYNC_W-1:0] filt_q;
  logic [SYNC_W-1:0] filt_d;

  assign raw_in = {rx_remote_pins, rx_lock, rx_pass, rx_frame_valid,
                   rx_line_valid, tx_frame_valid, tx_line_valid,
                   tx_synced, tx_interrupt, frame_sync_pulse};

  genvar gi;
  generate
    for (gi = 0; gi < SYNC_W; gi++) begin : g_sync
      always_comb begin
        filt_d[gi] = (s2_q[gi] == s3_q[gi]) ? s3_q[gi] : filt_q[gi];
      end
      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          s1_q[gi]   <= 1'b0;
          s2_q[gi]   <= 1'b0;
          s3_q[gi]   <= 1'b0;
          filt_q[gi] <= 1'b0;
        end else begin
          s1_q[gi]   <= raw_in[gi];
          s2_q[gi]   <= s1_q[gi];
          s3_q[gi]   <= s2_q[gi];
          filt_q[gi] <= filt_d[gi];
        end
      end
    end
  endgenerate

  logic [15:0] remote_s;
  logic [3:0]  lock_s;
  logic [3:0]  pass_s;
  logic [3:0]  fv_s;
  logic [3:0]  lv_s;
  logic        tx_fv_s;
  logic        tx_lv_s;
  logic        synced_s;
  logic        irq_s;
  logic        fsync_s;

  assign {remote_s, lock_s, pass_s, fv_s, lv_s, tx_fv_s, tx_lv_s,
          synced_s, irq_s, fsync_s} = filt_q;

  // Registers.
  logic [7:0]  ctl_q;
  logic [7:0]  ctl_d;
  logic [7:0]  cfg_q;
  logic [7:0]  cfg_d;
  logic [31:0] rdata_q;
  logic [31:0] rdata_d;
  logic        pin_q;
  logic        pin_d;

  logic            setup_ph;
  logic            wr_acc;
  logic            hit_ctl;
  logic            hit_cfg;
  logic            hit_stat;
  logic            hit_any;
  logic            rsvd_cfg;
  gpsm_src_t       src;
  logic [2:0]      sel;
  logic [1:0]      port;
  logic [3:0]      rx_en;
  logic [3:0]      tx_sel;

  assign src    = gpsm_src_t'(ctl_q[`GPSM_SRC_MSB:`GPSM_SRC_LSB]);
  assign sel    = ctl_q[`GPSM_SEL_MSB:`GPSM_SEL_LSB];
  assign port   = ctl_q[`GPSM_SRC_LSB+1:`GPSM_SRC_LSB];
  assign rx_en  = cfg_q[`GPSM_RX_EN_MSB:`GPSM_RX_EN_LSB];
  assign tx_sel = cfg_q[`GPSM_TX_SEL_MSB:`GPSM_TX_SEL_LSB];

  // Per-port terms for the aggregate selections. A port left out of the
  // group counts high for the AND terms and low for the OR terms.
  logic [3:0]  lock_hit;
  logic [3:0]  lock_fill;
  logic [3:0]  pass_fill;
  logic [3:0]  txp_hit;
  logic [3:0]  txp_fill;

  genvar gp;
  generate
    for (gp = 0; gp < `GPSM_RX_PORTS; gp++) begin : g_port
      assign lock_hit[gp]  = lock_s[gp] & rx_en[gp];
      assign lock_fill[gp] = lock_s[gp] | ~rx_en[gp];
      assign pass_fill[gp] = pass_s[gp] | ~rx_en[gp];
      assign txp_hit[gp]   = pass_s[gp] & tx_sel[gp];
      assign txp_fill[gp]  = pass_s[gp] | ~tx_sel[gp];
    end
  endgenerate

  // Address decode.
  always_comb begin
    hit_ctl  = 1'b0;
    hit_cfg  = 1'b0;
    hit_stat = 1'b0;
    if (paddr == `GPSM_PIN1_CTL_ADDR) begin
      hit_ctl = 1'b1;
    end else if (paddr == `GPSM_PORT_CFG_ADDR) begin
      hit_cfg = 1'b1;
    end else if (paddr == `GPSM_PIN_STAT_ADDR) begin
      hit_stat = 1'b1;
    end
  end

  assign hit_any  = hit_ctl | hit_cfg | hit_stat;
  assign setup_ph = psel & ~penable;
  // Every access completes in its first access cycle.
  assign pready   = 1'b1;
  assign pslverr  = psel & penable & ~hit_any;
  assign wr_acc   = psel & penable & pwrite & hit_any;
  assign prdata   = rdata_q;

  // A selection that lands on a reserved code is flagged for software.
  always_comb begin
    rsvd_cfg = 1'b0;
    if (src == gpsm_src_rsv5 || src == gpsm_src_rsv7) begin
      rsvd_cfg = 1'b1; // R1
    end else if (src == gpsm_src_dev && sel > 3'b100) begin
      rsvd_cfg = 1'b1; // R9
    end else if (src == gpsm_src_tx && sel > 3'b101) begin
      rsvd_cfg = 1'b1; // R13
    end
  end

  // Control registers.
  always_comb begin
    ctl_d = ctl_q;
    cfg_d = cfg_q;
    if (wr_acc && hit_ctl) begin
      ctl_d = pwdata[7:0]; // R14 R15
    end
    if (wr_acc && hit_cfg) begin
      cfg_d = pwdata[7:0];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctl_q <= `GPSM_PIN1_CTL_RST; // R15
      cfg_q <= `GPSM_PORT_CFG_RST;
    end else begin
      ctl_q <= ctl_d;
      cfg_q <= cfg_d;
    end
  end

  // Read data is captured in the setup cycle so that no access ever waits;
  // the status level read back is the one of the cycle before the access.
  always_comb begin
    rdata_d = rdata_q;
    if (setup_ph && !pwrite) begin
      rdata_d = 32'h0000_0000;
      if (hit_ctl) begin
        rdata_d[7:0] = ctl_q;
      end else if (hit_cfg) begin
        rdata_d[7:0] = cfg_q;
      end else if (hit_stat) begin
        rdata_d[`GPSM_STAT_LEVEL_BIT] = pin_q;
        rdata_d[`GPSM_STAT_OE_BIT]    = ctl_q[`GPSM_ENABLE_BIT];
        rdata_d[`GPSM_STAT_RSVD_BIT]  = rsvd_cfg;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rdata_q <= 32'h0000_0000;
    end else begin
      rdata_q <= rdata_d;
    end
  end

  // Output source selection. Reserved codes drive a low level.
  always_comb begin
    pin_d = 1'b0;
    case (src)
      gpsm_src_rx0, gpsm_src_rx1, gpsm_src_rx2, gpsm_src_rx3: begin // R1
        case (gpsm_rx_sel_t'(sel))
          gpsm_rx_pin0: pin_d = remote_s[{port, 2'b00}]; // R2
          gpsm_rx_pin1: pin_d = remote_s[{port, 2'b01}]; // R16
          gpsm_rx_pin2: pin_d = remote_s[{port, 2'b10}]; // R16
          gpsm_rx_pin3: pin_d = remote_s[{port, 2'b11}]; // R2
          gpsm_rx_lock: pin_d = lock_s[port]; // R3
          gpsm_rx_pass: pin_d = pass_s[port]; // R3
          gpsm_rx_fv:   pin_d = fv_s[port]; // R4
          gpsm_rx_lv:   pin_d = lv_s[port]; // R4
          default:      pin_d = 1'b0;
        endcase
      end
      gpsm_src_dev: begin // R1
        case (sel)
          gpsm_dev_level:    pin_d = ctl_q[`GPSM_LEVEL_BIT]; // R5
          gpsm_dev_lock_or:  pin_d = |lock_hit; // R6
          // With no port enabled the AND terms read low, not vacuously high.
          gpsm_dev_lock_and: pin_d = (|rx_en) & (&lock_fill); // R7
          gpsm_dev_pass_and: pin_d = (|rx_en) & (&pass_fill); // R8
          gpsm_dev_fsync:    pin_d = fsync_s; // R17
          default:           pin_d = 1'b0; // R9
        endcase
      end
      gpsm_src_tx: begin // R1
        case (sel)
          gpsm_tx_pass_and: pin_d = (|tx_sel) & (&txp_fill); // R10
          gpsm_tx_pass_or:  pin_d = |txp_hit; // R10
          gpsm_tx_fv:       pin_d = tx_fv_s; // R11
          gpsm_tx_lv:       pin_d = tx_lv_s; // R11
          gpsm_tx_synced:   pin_d = synced_s; // R12
          gpsm_tx_irq:      pin_d = irq_s; // R13
          default:          pin_d = 1'b0; // R13
        endcase
      end
      default: pin_d = 1'b0; // R1
    endcase
  end

  // The pin comes from a flip-flop so that a change of selection cannot
  // put a glitch on the board.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pin_q <= 1'b0;
    end else begin
      pin_q <= pin_d;
    end
  end

  // The level follows the selection even while the driver is off, so
  // turning the driver on shows a stale value only in the cycle after a write that also changes the selection.
  assign general_pin_one_o  = pin_q;
  assign general_pin_one_oe = ctl_q[`GPSM_ENABLE_BIT]; // R15

endmodule

`default_nettype wire

// file: gpsm_pin_mux_asserts.sv
`timescale 1ns/1ns
`default_nettype none
module gpsm_pin_mux_asserts (
  // Clock, reset and APB.
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic        pready,
  input wire logic        pslverr,
  // Status inputs and pin.
  input wire logic [15:0] rx_remote_pins,
  input wire logic [3:0]  rx_lock,
  input wire logic [3:0]  rx_pass,
  input wire logic        general_pin_one_o,
  input wire logic        general_pin_one_oe
);
  logic [7:0]  ctl_q;
  logic [7:0]  cfg_q;
  logic [23:0] prev_q;
  logic [3:0]  quiet_q;
  logic        wr;
  logic        ok;
  logic [2:0]  src;
  logic [2:0]  sel;
  assign wr  = psel && penable && pwrite;
  assign src = ctl_q[4:2];
  assign sel = ctl_q[7:5];
  // The pin lags its inputs by five edges, so only settled cycles count.
  assign ok  = quiet_q > 4'h6;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctl_q   <= 8'h00;
      cfg_q   <= 8'h00;
      prev_q  <= 24'h00_0000;
      quiet_q <= 4'h0;
    end else begin
      if (wr && paddr == 12'h044) ctl_q <= pwdata[7:0];
      if (wr && paddr == 12'h080) cfg_q <= pwdata[7:0];
      prev_q  <= {rx_remote_pins, rx_lock, rx_pass};
      if (wr || prev_q != {rx_remote_pins, rx_lock, rx_pass}) quiet_q <= 4'h0;
      else quiet_q <= quiet_q + {3'h0, quiet_q != 4'hf};
    end
  end
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  a_ready_high: assert property (pready) else $error("pready low");
  a_err_unmapped: assert property (psel && penable && !(paddr inside
    {12'h044, 12'h080, 12'h084}) |-> pslverr) else $error("no slverr");
  a_err_mapped: assert property (psel && penable && (paddr inside
    {12'h044, 12'h080, 12'h084}) |-> !pslverr) else $error("slverr");
  a_oe_write: assert property (wr && paddr == 12'h044 |=>
    general_pin_one_oe == $past(pwdata[0])) else $error("oe not set");
  a_oe_hold: assert property (!(wr && paddr == 12'h044) |=>
    $stable(general_pin_one_oe)) else $error("oe moved");
  a_level_drive: assert property (ok && src == 3'h4 && sel == 3'h0 |->
    general_pin_one_o == ctl_q[1]) else $error("level wrong");
  a_rx_pin: assert property (ok && !src[2] && !sel[2] |->
    general_pin_one_o == rx_remote_pins[{src[1:0], sel[1:0]}])
    else $error("remote pin wrong");
  a_rx_lock: assert property (ok && !src[2] && sel == 3'h4 |->
    general_pin_one_o == rx_lock[src[1:0]]) else $error("lock wrong");
  a_lock_or: assert property (ok && src == 3'h4 && sel == 3'h1 |->
    general_pin_one_o == |(rx_lock & cfg_q[3:0])) else $error("or wrong");
  a_lock_and: assert property (ok && src == 3'h4 && sel == 3'h2 |->
    general_pin_one_o == (cfg_q[3:0] != 4'h0 && &(rx_lock | ~cfg_q[3:0])))
    else $error("lock and wrong");
  a_tx_and: assert property (ok && src == 3'h6 && sel == 3'h0 |->
    general_pin_one_o == (cfg_q[7:4] != 4'h0 && &(rx_pass | ~cfg_q[7:4])))
    else $error("tx and wrong");
  a_rsv_zero: assert property (ok && src[2] && src[0] |->
    !general_pin_one_o) else $error("reserved source drives");
  c_level: cover property (ok && src == 3'h4 && sel == 3'h0);
  c_tx: cover property (ok && src == 3'h6);
  c_err: cover property (pslverr);
endmodule
bind gpsm_pin_mux gpsm_pin_mux_asserts gpsm_pin_mux_asserts_i (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready),
  .pslverr(pslverr), .rx_remote_pins(rx_remote_pins), .rx_lock(rx_lock),
  .rx_pass(rx_pass), .general_pin_one_o(general_pin_one_o),
  .general_pin_one_oe(general_pin_one_oe));
`default_nettype wire

// file: gpsm_pkg.sv
`default_nettype none

package gpsm_pkg;

  typedef enum logic [2:0] {
    gpsm_src_rx0  = 3'b000,
    gpsm_src_rx1  = 3'b001,
    gpsm_src_rx2  = 3'b010,
    gpsm_src_rx3  = 3'b011,
    gpsm_src_dev  = 3'b100,
    gpsm_src_rsv5 = 3'b101,
    gpsm_src_tx   = 3'b110,
    gpsm_src_rsv7 = 3'b111
  } gpsm_src_t;

  typedef enum logic [2:0] {
    gpsm_rx_pin0  = 3'b000,
    gpsm_rx_pin1  = 3'b001,
    gpsm_rx_pin2  = 3'b010,
    gpsm_rx_pin3  = 3'b011,
    gpsm_rx_lock  = 3'b100,
    gpsm_rx_pass  = 3'b101,
    gpsm_rx_fv    = 3'b110,
    gpsm_rx_lv    = 3'b111
  } gpsm_rx_sel_t;

  typedef enum logic [2:0] {
    gpsm_dev_level    = 3'b000,
    gpsm_dev_lock_or  = 3'b001,
    gpsm_dev_lock_and = 3'b010,
    gpsm_dev_pass_and = 3'b011,
    gpsm_dev_fsync    = 3'b100
  } gpsm_dev_sel_t;

  typedef enum logic [2:0] {
    gpsm_tx_pass_and = 3'b000,
    gpsm_tx_pass_or  = 3'b001,
    gpsm_tx_fv       = 3'b010,
    gpsm_tx_lv       = 3'b011,
    gpsm_tx_synced   = 3'b100,
    gpsm_tx_irq      = 3'b101
  } gpsm_tx_sel_t;

endpackage

`default_nettype wire

// file: gpsm_regs.svh
`ifndef GPSM_REGS_SVH
`define GPSM_REGS_SVH

// Register indices; the byte address on APB is four times the index.
`define GPSM_PIN1_CTL_IDX   8'h11
`define GPSM_PORT_CFG_IDX   8'h20
`define GPSM_PIN_STAT_IDX   8'h21
`define GPSM_PIN1_CTL_ADDR  12'h044
`define GPSM_PORT_CFG_ADDR  12'h080
`define GPSM_PIN_STAT_ADDR  12'h084

// Fields of pin1_output_control.
`define GPSM_SEL_MSB        7
`define GPSM_SEL_LSB        5
`define GPSM_SRC_MSB        4
`define GPSM_SRC_LSB        2
`define GPSM_LEVEL_BIT      1
`define GPSM_ENABLE_BIT     0
`define GPSM_PIN1_CTL_RST   8'h00

// Fields of the port configuration register.
`define GPSM_RX_EN_MSB      3
`define GPSM_RX_EN_LSB      0
`define GPSM_TX_SEL_MSB     7
`define GPSM_TX_SEL_LSB     4
`define GPSM_PORT_CFG_RST   8'h00

// Fields of the pin status register.
`define GPSM_STAT_LEVEL_BIT 0
`define GPSM_STAT_OE_BIT    1
`define GPSM_STAT_RSVD_BIT  2

`define GPSM_RX_PORTS       4
`define GPSM_PINS_PER_PORT  4

`endif

// file: testbench.sv
`timescale 1ns/1ns
`default_nettype none
module testbench;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, board_level;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rdata;
  logic [15:0] rx_remote_pins;
  logic [3:0] rx_lock, rx_pass, rx_frame_valid, rx_line_valid;
  logic tx_frame_valid, tx_line_valid, tx_synced, tx_interrupt;
  logic frame_sync_pulse, general_pin_one_o, general_pin_one_oe, err;
  logic [7:0] cfg, ctl;
  logic [44:0] pat;
  logic [2:0] st;
  int fails, check_count;
  assign {rx_remote_pins, rx_lock, rx_pass, rx_frame_valid, rx_line_valid,
    tx_frame_valid, tx_line_valid, tx_synced, tx_interrupt,
    frame_sync_pulse, cfg} = pat;
  gpsm_pin_mux gpsm_pin_mux_i (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .rx_remote_pins(rx_remote_pins),
    .rx_lock(rx_lock), .rx_pass(rx_pass), .rx_frame_valid(rx_frame_valid),
    .rx_line_valid(rx_line_valid), .tx_frame_valid(tx_frame_valid),
    .tx_line_valid(tx_line_valid), .tx_synced(tx_synced),
    .tx_interrupt(tx_interrupt), .frame_sync_pulse(frame_sync_pulse),
    .general_pin_one_o(general_pin_one_o),
    .general_pin_one_oe(general_pin_one_oe));
  gpsm_board_model gpsm_board_model_i (.general_pin_one_o,
    .general_pin_one_oe, .board_level);
  initial begin
    pclk = 1'b0;
    forever #10 pclk = ~pclk;
  end
  task automatic check(string what, logic [31:0] exp, logic [31:0] got);
    check_count++;
    if (got !== exp) begin
      fails++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic apb(logic wr, logic [11:0] a, logic [31:0] d);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rdata = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask
  function automatic logic rsv_exp(logic [7:0] c);
    return c[4:2] == 3'h5 || c[4:2] == 3'h7 ||
      (c[4:2] == 3'h4 && c[7:5] > 3'h4) || (c[4:2] == 3'h6 && c[7:5] > 3'h5);
  endfunction
  function automatic logic exp_pin(logic [7:0] c);
    logic [7:0] v;
    logic [3:0] en, ts;
    logic [1:0] k;
    en = cfg[3:0];
    ts = cfg[7:4];
    k = c[3:2];
    case (c[4:2])
      3'h4: v = {3'h0, frame_sync_pulse, |en && &(rx_pass | ~en),
        |en && &(rx_lock | ~en), |(rx_lock & en), c[1]};
      3'h6: v = {2'h0, tx_interrupt, tx_synced, tx_line_valid,
        tx_frame_valid, |(rx_pass & ts), |ts && &(rx_pass | ~ts)};
      3'h5, 3'h7: v = 8'h00;
      default: v = {rx_line_valid[k], rx_frame_valid[k], rx_pass[k],
        rx_lock[k], rx_remote_pins[{k, 2'h0} +: 4]};
    endcase
    return v[c[7:5]];
  endfunction
  task give_verdict;
    $display("checks %0d mismatches %0d", check_count, fails);
    if (fails == 0 && check_count > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  initial begin
    #(20 * 6000);
    fails++;
    give_verdict;
  end
  initial begin
    {presetn, psel, penable, pwrite, paddr, pwdata} = '0;
    pat = 45'h15a5_c369_3b5b;
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    check("oe", 32'h0, 32'(general_pin_one_oe));
    apb(1'b0, 12'h044, 32'h0);
    check("ctl reset", 32'h0, rdata);
    check("mapped slverr", 32'h0, 32'(err));
    apb(1'b0, 12'h084, 32'h0);
    check("status reset", 32'h0, rdata);
    apb(1'b0, 12'h0f0, 32'h0);
    check("slverr", 32'h1, 32'(err));
    check("unmapped read", 32'h0, rdata);
    apb(1'b1, 12'h044, 32'h0000_00a7);
    apb(1'b0, 12'h044, 32'h0);
    check("ctl", 32'h0000_00a7, rdata);
    // Both polarities of every input so a stuck output cannot pass.
    for (int p = 0; p < 2; p++) begin
      pat <= p[0] ? ~45'h15a5_c369_3b5b : 45'h15a5_c369_3b5b;
      apb(1'b1, 12'h080, {24'h0, p[0] ? ~8'h5b : 8'h5b});
      apb(1'b0, 12'h080, 32'h0);
      check("cfg", {24'h0, cfg}, rdata);
      for (int c = 0; c < 64; c++) begin
        ctl = {c[5:0], p[0], ~p[0]};
        apb(1'b1, 12'h044, {24'h0, ctl});
        repeat (6) @(posedge pclk);
        check("pin", 32'(exp_pin(ctl)), 32'(general_pin_one_o));
        check("board", 32'(exp_pin(ctl) & ~p[0]), 32'(board_level));
        st = {rsv_exp(ctl), ~p[0], exp_pin(ctl)};
        apb(1'b0, 12'h084, 32'h0);
        check("stat", {29'h0, st}, rdata);
      end
    end
    give_verdict;
  end
endmodule
`default_nettype wire
